// >>> emu_map_defs.svh
// constants for the emulation memory mapper
`ifndef EMU_MAP_DEFS_SVH
`define EMU_MAP_DEFS_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_MAP 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_CLR 8'h0c
`define REG_IRQ_EN 8'h10
`define REG_ENTRY 8'h14
// control field positions
`define CTRL_BRK_WR 0
`define CTRL_SEL_DRIVE 1
`define CTRL_SEL_RDINH 3
`define CTRL_EMULATING 4
// map attribute codes
`define ATTR_TARGET 2'h0
`define ATTR_RW 2'h1
`define ATTR_RO 2'h2
`define ATTR_NONE 2'h3
// reset values
`define CTRL_RESET 8'h02
`define IRQ_EN_RESET 2'h0
// event bits
`define EV_RO_WRITE 0
`define EV_NONE_ACC 1
// target cycle timing: edges before the synchronised wait reflects our strobe
`define TGT_SYNC_CYCLES 3'h3
`endif

// >>> emu_map_pkg.sv
// types for the emulation memory mapper
package emu_map_pkg;
	typedef enum logic [1:0] {
		area_target = 2'b00,
		area_rw = 2'b01,
		area_ro = 2'b10,
		area_none = 2'b11
	} area_type;
	typedef enum logic [1:0] {
		cyc_idle = 2'b00,
		cyc_target = 2'b01,
		cyc_hold = 2'b10
	} cyc_state_type;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic fetch;
		logic req;
	} cpu_bus_type;
	typedef struct packed {
		logic mem_request_strobe_n;
		logic rd_n;
		logic wr_n;
		logic fetch_n;
		logic [15:0] addr;
		logic [7:0] data;
		logic data_oe;
		logic ctl_oe;
	} tgt_bus_type;
endpackage

// >>> emulation_memory_mapper.sv
// emulation memory mapper: map, emulation ram and target bus steering
//
// Implementation choices: the address map and the Wishbone slave port.
`include "emu_map_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module emulation_memory_mapper
	import emu_map_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int BLOCK_W = 10
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// emulation processor bus, same clock
	input wire cpu_bus_type cpu_i,
	output logic [7:0] cpu_rdata_o,
	output logic cpu_ready_o,
	output logic break_o,
	// target system pins
	input wire logic tgt_wait_n_i,
	input wire logic [7:0] tgt_data_i,
	input wire logic bus_grant_ack_i,
	output tgt_bus_type tgt_o,
	// interrupt
	output logic irq_o
);
	localparam int ENTRIES = 1 << (ADDR_W - BLOCK_W);
	localparam int DEPTH = 1 << ADDR_W;
	localparam int IDX_W = ADDR_W - BLOCK_W;

	initial
	begin
		if (ADDR_W != 16 || BLOCK_W < 1 || BLOCK_W >= ADDR_W)
			$error("unsupported address or block width");
		// the entry register and the read path carry at most 32 bits
		if (IDX_W > 32)
			$error("map index too wide");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] ctrl;
		logic [ENTRIES-1:0][1:0] map;
		logic [1:0] status;
		logic [1:0] irq_en;
		logic [IDX_W-1:0] entry;
		logic [31:0] dat;
		logic ack;
		logic irq;
		logic brk;
		logic [7:0] rdata;
		logic ready;
		tgt_bus_type tgt;
		logic [1:0] wsync1;
		logic [1:0] wsync2;
		cyc_state_type cyc;
		logic [2:0] cnt;
		logic gsync1;
		logic gsync2;
		logic [7:0] dsync1;
		logic [7:0] dsync2;
	} state_type;

	state_type s_q, s_d;
	// emulation ram, 64K bytes
	logic [7:0] emu_ram [DEPTH];
	logic [7:0] ram_q;
	logic ram_we;

	// ----------------------------------------------------------------
	// map decode
	// ----------------------------------------------------------------
	// one flag set per entry keeps the lookup a plain bit select
	logic [ENTRIES-1:0] ent_emu;
	logic [ENTRIES-1:0] ent_ro;
	logic [ENTRIES-1:0] ent_none;

	generate
		for (genvar g = 0; g < ENTRIES; g++)
		begin : g_entry
			assign ent_emu[g] = s_q.map[g] == `ATTR_RW
				|| s_q.map[g] == `ATTR_RO;
			assign ent_ro[g] = s_q.map[g] == `ATTR_RO;
			assign ent_none[g] = s_q.map[g] == `ATTR_NONE;
		end
	endgenerate

	// ----------------------------------------------------------------
	// combinational decode
	// ----------------------------------------------------------------
	logic [IDX_W-1:0] blk;
	logic mapped;
	area_type area;
	logic idle;
	logic grant;
	logic emu_acc;
	logic tgt_acc;
	logic tgt_done;
	logic bus_wr;
	logic [1:0] ev;

	always_comb
	begin
		blk = cpu_i.addr[ADDR_W-1:BLOCK_W];
		// outside mode one every access goes to the target
		mapped = s_q.ctrl[`CTRL_EMULATING];
		if (mapped && ent_none[blk])
			area = area_none;
		else if (mapped && ent_ro[blk])
			area = area_ro;
		else if (mapped && ent_emu[blk])
			area = area_rw;
		else
			area = area_target;
		idle = s_q.cyc == cyc_idle;
		grant = s_q.gsync2;
		// a request is taken once; its held copy is ignored later
		emu_acc = idle && cpu_i.req && (area == area_rw || area == area_ro);
		tgt_acc = idle && cpu_i.req && area == area_target && !grant;
		// wait is trusted only once the synchroniser has seen our strobe
		tgt_done = s_q.cyc == cyc_target
			&& s_q.cnt >= `TGT_SYNC_CYCLES && s_q.wsync2[0];
		// register writes land at the edge the master sees ack
		bus_wr = cyc_i && stb_i && we_i && s_q.ack;
		ram_we = emu_acc && cpu_i.wr && area == area_rw;
		ev = 2'b00;
		if (emu_acc && cpu_i.wr && area == area_ro
			&& s_q.ctrl[`CTRL_BRK_WR])
			ev[`EV_RO_WRITE] = 1'b1;
		if (idle && cpu_i.req && area == area_none)
			ev[`EV_NONE_ACC] = 1'b1;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// ----------------------------------------------------------------
		// synchronisers for the target pins
		// ----------------------------------------------------------------
		s_d.wsync1 = {1'b0, tgt_wait_n_i};
		s_d.wsync2 = s_q.wsync1;
		s_d.gsync1 = bus_grant_ack_i;
		s_d.gsync2 = s_q.gsync1;
		// data is only taken long after it settled, so bits cannot skew
		s_d.dsync1 = tgt_data_i;
		s_d.dsync2 = s_q.dsync1;
		// ----------------------------------------------------------------
		// register bus
		// ----------------------------------------------------------------
		// ack one cycle after the request, for one cycle
		s_d.ack = cyc_i && stb_i && !s_q.ack;
		s_d.dat = 32'h0;
		if (cyc_i && stb_i && !s_q.ack)
		begin
			case (adr_i)
				`REG_CTRL: s_d.dat = {24'h0, s_q.ctrl};
				`REG_MAP: s_d.dat = {30'h0, s_q.map[s_q.entry]};
				`REG_STATUS: s_d.dat = {30'h0, s_q.status};
				`REG_IRQ_EN: s_d.dat = {30'h0, s_q.irq_en};
				`REG_ENTRY: s_d.dat = {{(32-IDX_W){1'b0}}, s_q.entry};
				default: s_d.dat = 32'h0;
			endcase
		end
		if (bus_wr && sel_i[0])
		begin
			case (adr_i)
				`REG_CTRL: s_d.ctrl = dat_i[7:0];
				`REG_MAP: s_d.map[s_q.entry] = dat_i[1:0];
				`REG_IRQ_CLR: s_d.status = s_q.status & ~dat_i[1:0];
				`REG_IRQ_EN: s_d.irq_en = dat_i[1:0];
				`REG_ENTRY: s_d.entry = dat_i[IDX_W-1:0];
				default: ;
			endcase
		end
		// set wins over clear
		s_d.status = s_d.status | ev;
		s_d.irq = |(s_d.status & s_d.irq_en);
		s_d.brk = |ev;
		// ----------------------------------------------------------------
		// cpu cycle sequencing
		// ----------------------------------------------------------------
		s_d.ready = 1'b0;
		case (s_q.cyc)
			cyc_idle:
			begin
				s_d.cnt = 3'h0;
				if (cpu_i.req && (emu_acc || area == area_none))
				begin
					// emulation blocks answer at once, target wait unseen
					s_d.ready = 1'b1;
					s_d.rdata = ram_q;
					s_d.cyc = cyc_hold;
				end
				else if (tgt_acc)
					s_d.cyc = cyc_target;
			end
			cyc_target:
			begin
				if (s_q.cnt != 3'h7)
					s_d.cnt = s_q.cnt + 3'h1;
				if (tgt_done)
				begin
					s_d.ready = 1'b1;
					s_d.rdata = s_q.dsync2;
					s_d.cyc = cyc_hold;
				end
			end
			cyc_hold:
				// the master still shows its request on this edge
				s_d.cyc = cyc_idle;
			default:
				s_d.cyc = cyc_idle;
		endcase
		// ----------------------------------------------------------------
		// target pins
		// ----------------------------------------------------------------
		s_d.tgt.ctl_oe = !grant;
		// outside idle the pins keep the strobes of the running cycle
		if (s_q.cyc == cyc_idle)
		begin
			s_d.tgt.addr = cpu_i.addr;
			s_d.tgt.mem_request_strobe_n = 1'b1;
			s_d.tgt.rd_n = 1'b1;
			s_d.tgt.wr_n = 1'b1;
			s_d.tgt.fetch_n = !(cpu_i.req && cpu_i.fetch);
			s_d.tgt.data = cpu_i.wdata;
			s_d.tgt.data_oe = 1'b0;
			if (cpu_i.req && !grant)
			begin
				case (area)
					area_target:
					begin
						s_d.tgt.mem_request_strobe_n = 1'b0;
						s_d.tgt.rd_n = !cpu_i.rd;
						s_d.tgt.wr_n = !cpu_i.wr;
						s_d.tgt.data_oe = cpu_i.wr;
					end
					area_rw, area_ro:
					begin
						// reads keep mem_request_strobe visible for peripherals, and rd unless CTRL_SEL_RDINH is set
						s_d.tgt.mem_request_strobe_n = !cpu_i.rd;
						s_d.tgt.rd_n = !(cpu_i.rd &&
							!s_q.ctrl[`CTRL_SEL_RDINH]);
						s_d.tgt.wr_n = 1'b1;
						s_d.tgt.data = cpu_i.wr ? cpu_i.wdata : ram_q;
						s_d.tgt.data_oe = cpu_i.wr ||
							s_q.ctrl[`CTRL_SEL_DRIVE];
					end
					default:
					begin
						// non-existent: nothing reaches either memory
						s_d.tgt.fetch_n = 1'b1;
					end
				endcase
			end
		end
		if (grant)
			s_d.tgt.data_oe = 1'b0;
		// ----------------------------------------------------------------
		// reset
		// ----------------------------------------------------------------
		if (rst_i)
		begin
			s_d = '0;
			s_d.ctrl = `CTRL_RESET;
			s_d.irq_en = `IRQ_EN_RESET;
			for (int i = 0; i < ENTRIES; i++)
				s_d.map[i] = `ATTR_TARGET;
			s_d.tgt.mem_request_strobe_n = 1'b1;
			s_d.tgt.rd_n = 1'b1;
			s_d.tgt.wr_n = 1'b1;
			s_d.tgt.fetch_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		s_q <= s_d;
	end

	// ----------------------------------------------------------------
	// emulation ram
	// ----------------------------------------------------------------
	// ram read is combinational on the address so data is ready this cycle
	assign ram_q = emu_ram[cpu_i.addr];

	always_ff @(posedge clk_i)
	begin
		if (ram_we)
			emu_ram[cpu_i.addr] <= cpu_i.wdata;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dat_o = s_q.dat;
	assign ack_o = s_q.ack;
	assign irq_o = s_q.irq;
	assign break_o = s_q.brk;
	assign cpu_rdata_o = s_q.rdata;
	assign cpu_ready_o = s_q.ready;
	assign tgt_o = s_q.tgt;
endmodule // emulation_memory_mapper
`default_nettype wire

// >>> emm_chk.sv
// checker for the emulation memory mapper
`timescale 1ns/1ns
`default_nettype none
module emm_chk
	import emu_map_pkg::*;
(
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire cpu_bus_type cpu_i,
	input wire logic cpu_ready_o,
	input wire logic break_o,
	input wire logic bus_grant_ack_i,
	input wire tgt_bus_type tgt_o
);
// shadow of the map, taken from bus writes at the ack edge
logic [7:0] ctl_q;
logic [5:0] idx_q;
area_type map_q [64];
area_type ar;
logic emu, go, wr, rd;
assign ar = ctl_q[4] ? map_q[cpu_i.addr[15:10]] : area_target;
assign emu = ar == area_rw || ar == area_ro;
// the held second edge of a request is not a new access
assign go = cpu_i.req && !cpu_ready_o && !bus_grant_ack_i;
assign wr = go && cpu_i.wr;
assign rd = go && cpu_i.rd;
always_ff @(posedge clk_i)
	if (rst_i)
	begin
		ctl_q <= 8'h02;
		idx_q <= 6'h00;
		foreach (map_q[i])
			map_q[i] <= area_target;
	end
	else if (cyc_i && stb_i && we_i && ack_o)
	begin
		if (adr_i == 8'h00)
			ctl_q <= dat_i[7:0];
		if (adr_i == 8'h14)
			idx_q <= dat_i[5:0];
		if (adr_i == 8'h04)
			map_q[idx_q] <= area_type'(dat_i[1:0]);
	end
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
ro_break_a: assert property (wr && ar == area_ro && ctl_q[0] |=> break_o)
	else $error("no ro break");
none_break_a: assert property (go && ar == area_none |=> break_o)
	else $error("no none break");
emu_write_a: assert property (wr && emu |=> tgt_o.mem_request_strobe_n && tgt_o.wr_n)
	else $error("target strobed");
rd_inhibit_a: assert property (rd && emu && ctl_q[3] |=> tgt_o.rd_n)
	else $error("rd not held");
data_float_a: assert property (rd && emu && !ctl_q[1] |=> !tgt_o.data_oe)
	else $error("data driven");
data_drive_a: assert property (rd && emu && ctl_q[1] |=> tgt_o.data_oe)
	else $error("data floats");
grant_float_a: assert property (bus_grant_ack_i |-> ##3 !tgt_o.ctl_oe)
	else $error("pins driven");
tgt_route_a: assert property (go && ar == area_target |-> ##[1:4] !tgt_o.mem_request_strobe_n)
	else $error("target not used");
endmodule // emm_chk
bind emulation_memory_mapper emm_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .dat_i, .ack_o, .cpu_i, .cpu_ready_o, .break_o,
	.bus_grant_ack_i, .tgt_o);
`default_nettype wire

// >>> tgt_sys.sv
// target bus model: memory with slow wait answers
`timescale 1ns/1ns
`default_nettype none
module tgt_sys
	import emu_map_pkg::*;
(
	input wire logic clk_i,
	input wire tgt_bus_type tgt_i,
	input wire logic [1:0] slow_i,
	output logic wait_n_o,
	output logic [7:0] data_o
);
logic [7:0] mem [65536];
logic [1:0] cnt = 2'h0;
logic sel;
initial data_o = 8'h5a;
initial wait_n_o = 1'h1;
assign sel = tgt_i.ctl_oe && !tgt_i.mem_request_strobe_n;
// only a selected read shows memory; else lines toggle
always @(posedge clk_i)
begin
	cnt <= tgt_i.mem_request_strobe_n ? slow_i : (cnt == 2'h0 ? cnt : cnt - 2'h1);
	wait_n_o <= tgt_i.mem_request_strobe_n || cnt == 2'h0;
	if (sel && !tgt_i.wr_n)
		mem[tgt_i.addr] <= tgt_i.data;
	data_o <= (sel && !tgt_i.rd_n) ? mem[tgt_i.addr] : ~data_o;
end
// no dma is started across the two spaces
endmodule // tgt_sys
`default_nettype wire

// >>> emulation_memory_mapper_test.sv
// testbench for the emulation memory mapper
`timescale 1ns/1ns
`default_nettype none
module emulation_memory_mapper_test
	import emu_map_pkg::*;
;
logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, gnt = 0;
logic [7:0] adr_i = 8'h00, cpu_rdata_o, td;
logic [31:0] dat_i = 32'h0, dat_o, q;
logic ack_o, cpu_ready_o, break_o, irq_o, wn;
logic [1:0] slow = 2'h2;
cpu_bus_type cpu_i = '0;
tgt_bus_type tgt_o;
int err_total = 0, comparisons = 0, ticks = 0, brk = 0, b;
emulation_memory_mapper DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .sel_i(4'h1), .dat_i, .dat_o, .ack_o, .cpu_i, .cpu_rdata_o,
	.cpu_ready_o, .break_o, .tgt_wait_n_i(wn), .tgt_data_i(td),
	.bus_grant_ack_i(gnt), .tgt_o, .irq_o);
tgt_sys far (.clk_i, .tgt_i(tgt_o), .slow_i(slow), .wait_n_o(wn),
	.data_o(td));
initial forever #50 clk_i = ~clk_i;
always @(posedge clk_i)
begin
	brk <= brk + int'(break_o);
	ticks <= ticks + 1;
	if (ticks == 3000)
	begin
		err_total++;
		close_out;
	end
end
task close_out;
	$display("compares %0d bad %0d", comparisons, err_total);
	if (err_total == 0 && comparisons > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
task chk(input logic [31:0] g, e);
	comparisons++;
	if (g !== e)
	begin
		err_total++;
		$display("BAD %0t got %h exp %h", $time, g, e);
	end
endtask
task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge clk_i);
	cyc_i <= 1'h1;
	stb_i <= 1'h1;
	we_i <= w;
	adr_i <= a;
	dat_i <= d;
	do @(posedge clk_i); while (ack_o !== 1'h1);
	q = dat_o;
	cyc_i <= 1'h0;
	stb_i <= 1'h0;
endtask
task cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
	@(posedge clk_i);
	cpu_i <= '{a, d, !w, w, 1'h0, 1'h1};
	do @(posedge clk_i); while (cpu_ready_o !== 1'h1);
	q = 32'(cpu_rdata_o);
	cpu_i <= '0;
endtask
task t_reset;
	wb(0, 8'h00, 0);
	chk(q, 32'h02);
	cpu(1, 16'h0400, 8'h11);
	cpu(0, 16'h0400, 0);
	chk(q, 32'h11);
	wb(0, 8'h20, 0);
	chk(q, 32'h0);
	$display("reset test done");
endtask
task t_emu;
	wb(1, 8'h00, 32'h13);
	wb(1, 8'h14, 32'h01);
	wb(1, 8'h04, 32'h01);
	cpu(1, 16'h0400, 8'h22);
	cpu(0, 16'h0400, 0);
	chk(q, 32'h22);
	wb(1, 8'h04, 32'h00);
	cpu(0, 16'h0400, 0);
	chk(q, 32'h11);
	$display("emulation test done");
endtask
task t_ro;
	wb(1, 8'h14, 32'h02);
	wb(1, 8'h04, 32'h01);
	cpu(1, 16'h0800, 8'h33);
	wb(1, 8'h04, 32'h02);
	b = brk;
	cpu(1, 16'h0800, 8'h44);
	cpu(0, 16'h0800, 0);
	chk(q, 32'h33);
	chk(brk - b, 1);
	chk(irq_o, 0);
	wb(1, 8'h10, 32'h01);
	repeat (2) @(posedge clk_i);
	chk(irq_o, 1);
	wb(1, 8'h0c, 32'h01);
	repeat (2) @(posedge clk_i);
	chk(irq_o, 0);
	$display("read only test done");
endtask
task t_none;
	wb(1, 8'h14, 32'h03);
	wb(1, 8'h04, 32'h03);
	b = brk;
	cpu(0, 16'h0c00, 0);
	repeat (2) @(posedge clk_i);
	chk(brk - b, 1);
	wb(0, 8'h08, 0);
	chk(q & 32'h2, 32'h2);
	wb(1, 8'h00, 32'h18);
	cpu(0, 16'h0800, 0);
	chk(q, 32'h33);
	gnt <= 1'h1;
	repeat (4) @(posedge clk_i);
	chk(tgt_o.ctl_oe, 0);
	gnt <= 1'h0;
	$display("none and select test done");
endtask
initial
begin
	repeat (2) @(posedge clk_i);
	rst_i <= 1'h0;
	t_reset;
	t_emu;
	t_ro;
	t_none;
	close_out;
end
endmodule // emulation_memory_mapper_test
`default_nettype wire
